/* verilog/drup_pkg.sv */
// Package for the DRAM user request port: command codes, widths, timing.
// Assumes nothing of its surroundings; imported by every design file.
package drup_pkg;
	localparam logic [2:0] CMD_WRITE = 3'h0;
	localparam logic [2:0] CMD_READ = 3'h1;
	localparam int ADDR_W = 28;
	localparam int DATA_W = 128;
	localparam int MASK_W = DATA_W / 8;
	localparam int ERR_W = 8;
	localparam int BEATS = 2;
	localparam int BANKS = 4;
	localparam int RD_SLOTS = 4;
	localparam int WR_SLOTS = 4;
	localparam int MEM_WORDS = 16;
	// Calibration time in ns, converted to user clock cycles
	localparam int CAL_TIME_NS = 2000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int CAL_CYCLES = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PERIODIC_INTERVAL = 64;
	localparam int SERVICE_CYCLES = 3;
	localparam logic [1:0] CAL_RESET = 2'h0;
	typedef enum logic [2:0] {
		DRUP_IDLE = 3'b001,
		DRUP_SERVE = 3'b010,
		DRUP_PERIODIC = 3'b100
	} drup_state_t;
endpackage

/* verilog/drup_store_if.sv */
// Interface between the request port and its storage array.
// Assumes one clock shared by both sides.
`timescale 1ns/1ps
interface drup_store_if;
	import drup_pkg::*;
	logic wrEn;
	logic [3:0] wrIdx;
	logic [DATA_W-1:0] wrData;
	logic [MASK_W-1:0] wrMask;
	logic [3:0] rdIdx;
	logic [DATA_W-1:0] rdData;
	logic [ERR_W-1:0] rdErr;
	modport port(output wrEn, wrIdx, wrData, wrMask, rdIdx, input rdData, rdErr);
	modport store(input wrEn, wrIdx, wrData, wrMask, rdIdx, output rdData, rdErr);
endinterface

/* verilog/drup_store.sv */
// Flip-flop backing store standing in for the external array.
// Assumes mask bit set means byte is kept; error flags come from a test input.
`timescale 1ns/1ps
module drup_store
	import drup_pkg::*;
(
	// Clock
	input wire logic clock,
	// Access
	drup_store_if.store st,
	input wire logic [ERR_W-1:0] injectErr
);
	logic [DATA_W-1:0] mem [MEM_WORDS];
	logic [DATA_W-1:0] merged;
	always_comb begin
		merged = mem[st.wrIdx];
		for (int b = 0; b < MASK_W; b++) begin
			if (!st.wrMask[b]) begin
				merged[b*8 +: 8] = st.wrData[b*8 +: 8];
			end
		end
	end
	always_ff @(posedge clock) begin
		if (st.wrEn) begin
			mem[st.wrIdx] <= merged;
		end
	end
	// Double-bit errors pass data through uncorrected
	assign st.rdData = mem[st.rdIdx];
	assign st.rdErr = injectErr;
endmodule // drup_store

/* verilog/drup_user_port.sv */
// User request port of the DRAM controller: handshake, buffering, read return.
// Assumes requester logic on the same clock; the store module models the array.
// Notes on behaviour
// - Flat address space; read and write data are buffered inside the port.
// - Request taken only when strobe and accept both high; else retried.
// - Command 001 is read, 000 is write.
// - Accept low before calibration, banks full, buffers full, periodic read.
// - Priority-boosted requests are served before normal ones.
// - Write word taken only when write ready and write valid both high.
// - Read valid high exactly when read data holds a valid word.
// - Read last beat marks the final word of each read.
// - User clock is a quarter of DRAM clock; memory clock also provided.
// - Calibration done rises once calibration finishes.
// - Error flags appear with read valid, non-zero on double-bit errors.
// - Data with double-bit errors is returned uncorrected.
// - Optional reordering of pending requests.
// - Reset is active high for the user port.
`timescale 1ns/1ps
module drup_user_port
	import drup_pkg::*;
#(
	parameter bit REORDER = 1'b1
) (
	// Clocks and reset
	input wire logic clock,
	input wire logic clockMem,
	input wire logic rst_n,
	input wire logic userReset,
	// Request
	input wire logic requestStrobe,
	input wire logic [2:0] requestCommand,
	input wire logic [ADDR_W-1:0] requestAddress,
	input wire logic reservedSizeInput,
	input wire logic priorityBoost,
	output logic requestAccept,
	// Write data
	input wire logic [DATA_W-1:0] writePayload,
	input wire logic [MASK_W-1:0] writeByteMask,
	input wire logic writePayloadValid,
	input wire logic writeLastBeat,
	output logic writeFifoReady,
	// Read data
	output logic [DATA_W-1:0] readReturnData,
	output logic readReturnValid,
	output logic readLastBeat,
	output logic [ERR_W-1:0] uncorrectableErrorFlags,
	// Status and model hooks
	input wire logic [ERR_W-1:0] injectErr,
	output logic calibrationDone
);
	drup_store_if st();
	drup_store u_store (
		.clock(clock),
		.st(st),
		.injectErr(injectErr)
	);

	// clockMem only feeds serialisers beyond this block
	logic memClockUnused;
	assign memClockUnused = clockMem;

	// Both resets hold the port; user reset is active high
	logic resetAll;
	assign resetAll = !rst_n || userReset;

	// Bank machines: one pending request each
	logic [BANKS-1:0] bValid_reg, bValid_next;
	logic [BANKS-1:0] bRead_reg, bRead_next;
	logic [BANKS-1:0] bHi_reg, bHi_next;
	logic [3:0] bAddr_reg [BANKS], bAddr_next [BANKS];
	logic [2:0] wrCnt_reg, wrCnt_next;
	logic [DATA_W-1:0] wData_reg [WR_SLOTS], wData_next [WR_SLOTS];
	logic [MASK_W-1:0] wMask_reg [WR_SLOTS], wMask_next [WR_SLOTS];
	logic [2:0] wWords_reg, wWords_next;
	logic [2:0] rdOut_reg, rdOut_next;
	logic [11:0] calCnt_reg, calCnt_next;
	logic calDone_reg, calDone_next;
	logic [6:0] perCnt_reg, perCnt_next;
	drup_state_t state_reg, state_next;
	logic [1:0] svc_reg, svc_next;
	logic [1:0] sel_reg, sel_next;
	logic beat_reg, beat_next;
	logic accept_reg, accept_next;
	logic wfReady_reg, wfReady_next;
	logic [DATA_W-1:0] rData_reg, rData_next;
	logic rValid_reg, rValid_next;
	logic rLast_reg, rLast_next;
	logic [ERR_W-1:0] rErr_reg, rErr_next;

	logic take, isRead, freeBank, wordIn, pick, pickHi;
	logic [1:0] freeIdx, pickIdx;

	always_comb begin
		freeBank = 1'b0;
		freeIdx = 2'h0;
		for (int i = BANKS - 1; i >= 0; i--) begin
			if (!bValid_reg[i]) begin
				freeBank = 1'b1;
				freeIdx = 2'(i);
			end
		end
		// Lowest index first, boosted requests win when reordering
		pick = 1'b0;
		pickHi = 1'b0;
		pickIdx = 2'h0;
		for (int i = BANKS - 1; i >= 0; i--) begin
			// A write waiting for its data must not block serviceable requests
			if (bValid_reg[i] && (bRead_reg[i] || wWords_reg >= 3'(BEATS))) begin
				if (!pick || !REORDER || (bHi_reg[i] && !pickHi) || bHi_reg[i] == pickHi) begin
					if (!(REORDER && pickHi && !bHi_reg[i])) begin
						pick = 1'b1;
						pickHi = bHi_reg[i];
						pickIdx = 2'(i);
					end
				end
			end
		end
	end

	assign isRead = (requestCommand == CMD_READ);
	assign take = requestStrobe && accept_reg;
	assign wordIn = writePayloadValid && wfReady_reg;

	always_comb begin
		bValid_next = bValid_reg;
		bRead_next = bRead_reg;
		bHi_next = bHi_reg;
		bAddr_next = bAddr_reg;
		wData_next = wData_reg;
		wMask_next = wMask_reg;
		wWords_next = wWords_reg;
		wrCnt_next = wrCnt_reg;
		rdOut_next = rdOut_reg;
		calCnt_next = calCnt_reg;
		calDone_next = calDone_reg;
		perCnt_next = perCnt_reg + 7'h1;
		state_next = state_reg;
		svc_next = svc_reg;
		sel_next = sel_reg;
		beat_next = beat_reg;
		rValid_next = 1'b0;
		rLast_next = 1'b0;
		rData_next = rData_reg;
		rErr_next = '0;
		st.wrEn = 1'b0;
		st.wrIdx = bAddr_reg[sel_reg];
		st.wrData = wData_reg[0];
		st.wrMask = wMask_reg[0];
		st.rdIdx = bAddr_reg[sel_reg];

		if (calCnt_reg != 12'(CAL_CYCLES)) begin
			calCnt_next = calCnt_reg + 12'h1;
		end else begin
			calDone_next = 1'b1;
		end

		if (wordIn) begin
			wData_next[wWords_reg[1:0]] = writePayload;
			wMask_next[wWords_reg[1:0]] = writeByteMask;
			wWords_next = wWords_reg + 3'h1;
		end

		if (take) begin
			bValid_next[freeIdx] = 1'b1;
			bRead_next[freeIdx] = isRead;
			bHi_next[freeIdx] = priorityBoost;
			bAddr_next[freeIdx] = requestAddress[3:0];
			if (isRead) begin
				rdOut_next = rdOut_next + 3'h1;
			end else begin
				wrCnt_next = wrCnt_next + 3'h1;
			end
		end

		unique case (state_reg)
			DRUP_IDLE: begin
				if (perCnt_reg == 7'(PERIODIC_INTERVAL - 1)) begin
					state_next = DRUP_PERIODIC;
					svc_next = 2'h0;
				end else if (pick && (bRead_reg[pickIdx] || wWords_reg >= 3'(BEATS))) begin
					state_next = DRUP_SERVE;
					sel_next = pickIdx;
					beat_next = 1'b0;
				end
			end
			DRUP_SERVE: begin
				if (bRead_reg[sel_reg]) begin
					rValid_next = 1'b1;
					rData_next = st.rdData;
					rErr_next = st.rdErr;
					rLast_next = beat_reg;
				end else begin
					st.wrEn = !beat_reg;
					if (beat_reg) begin
						for (int i = 0; i < WR_SLOTS - BEATS; i++) begin
							wData_next[i] = wData_next[i + BEATS];
							wMask_next[i] = wMask_next[i + BEATS];
						end
						wWords_next = wWords_next - 3'(BEATS);
						wrCnt_next = wrCnt_next - 3'h1;
					end
				end
				beat_next = !beat_reg;
				if (beat_reg) begin
					bValid_next[sel_reg] = 1'b0;
					if (bRead_reg[sel_reg]) begin
						rdOut_next = rdOut_next - 3'h1;
					end
					state_next = DRUP_IDLE;
				end
			end
			DRUP_PERIODIC: begin
				svc_next = svc_reg + 2'h1;
				perCnt_next = 7'h0;
				if (svc_reg == 2'(SERVICE_CYCLES - 1)) begin
					state_next = DRUP_IDLE;
				end
			end
		endcase

		// Accept is registered; the read limit and write ready keep a margin of one, while write requests and banks may fill to capacity
		accept_next = calDone_next && (state_next != DRUP_PERIODIC) && freeBank
			&& (bValid_next != {BANKS{1'b1}})
			&& !(isRead && rdOut_next >= 3'(RD_SLOTS - 1))
			&& !(!isRead && wrCnt_next >= 3'(WR_SLOTS / BEATS));
		wfReady_next = calDone_next && (wWords_next <= 3'(WR_SLOTS - 2));
	end

	always_ff @(posedge clock) begin
		if (resetAll) begin
			bValid_reg <= '0;
			bRead_reg <= '0;
			bHi_reg <= '0;
			for (int i = 0; i < BANKS; i++) begin
				bAddr_reg[i] <= 4'h0;
			end
			for (int i = 0; i < WR_SLOTS; i++) begin
				wData_reg[i] <= '0;
				wMask_reg[i] <= '0;
			end
			wWords_reg <= 3'h0;
			wrCnt_reg <= 3'h0;
			rdOut_reg <= 3'h0;
			calCnt_reg <= 12'h0;
			calDone_reg <= 1'b0;
			perCnt_reg <= 7'h0;
			state_reg <= DRUP_IDLE;
			svc_reg <= CAL_RESET;
			sel_reg <= 2'h0;
			beat_reg <= 1'b0;
			accept_reg <= 1'b0;
			wfReady_reg <= 1'b0;
			rData_reg <= '0;
			rValid_reg <= 1'b0;
			rLast_reg <= 1'b0;
			rErr_reg <= '0;
		end else begin
			bValid_reg <= bValid_next;
			bRead_reg <= bRead_next;
			bHi_reg <= bHi_next;
			bAddr_reg <= bAddr_next;
			wData_reg <= wData_next;
			wMask_reg <= wMask_next;
			wWords_reg <= wWords_next;
			wrCnt_reg <= wrCnt_next;
			rdOut_reg <= rdOut_next;
			calCnt_reg <= calCnt_next;
			calDone_reg <= calDone_next;
			perCnt_reg <= perCnt_next;
			state_reg <= state_next;
			svc_reg <= svc_next;
			sel_reg <= sel_next;
			beat_reg <= beat_next;
			accept_reg <= accept_next;
			wfReady_reg <= wfReady_next;
			rData_reg <= rData_next;
			rValid_reg <= rValid_next;
			rLast_reg <= rLast_next;
			rErr_reg <= rErr_next;
		end
	end

	assign requestAccept = accept_reg;
	assign writeFifoReady = wfReady_reg;
	assign readReturnData = rData_reg;
	assign readReturnValid = rValid_reg;
	assign readLastBeat = rLast_reg;
	assign uncorrectableErrorFlags = rErr_reg;
	assign calibrationDone = calDone_reg;
endmodule // drup_user_port

/* test/drup_user_port_sva.sv */
// Checker for the DRAM user request port, bound to its top module.
// Assumes one clock; both resets are sampled on it.
`timescale 1ns/1ps
module drup_user_port_sva
	import drup_pkg::*;
(
	// Clock and resets
	input wire logic clock,
	input wire logic rst_n,
	input wire logic userReset,
	// Observed ports
	input wire logic requestStrobe,
	input wire logic [2:0] requestCommand,
	input wire logic requestAccept,
	input wire logic writeFifoReady,
	input wire logic readReturnValid,
	input wire logic readLastBeat,
	input wire logic [ERR_W-1:0] uncorrectableErrorFlags,
	input wire logic calibrationDone
);
	logic [8:0] calCnt_reg;
	logic [8:0] calCnt_next;
	// Edges since either reset let go, saturating
	always_comb begin
		calCnt_next = calCnt_reg;
		if (!rst_n || userReset)
			calCnt_next = 9'h0;
		else if (calCnt_reg != 9'h1ff)
			calCnt_next = calCnt_reg + 9'h1;
	end
	always_ff @(posedge clock) begin
		calCnt_reg <= calCnt_next;
	end
	held_in_reset_a: assert property (@(posedge clock) disable iff (!rst_n)
		userReset |=> !requestAccept && !writeFifoReady && !readReturnValid && !calibrationDone)
		else $error("port active in reset");
	accept_needs_cal_a: assert property (@(posedge clock) disable iff (!rst_n || userReset)
		!calibrationDone |-> !requestAccept) else $error("accept before calibration");
	cal_early_a: assert property (@(posedge clock) disable iff (!rst_n || userReset)
		$rose(calibrationDone) |-> calCnt_reg >= 9'(CAL_CYCLES)) else $error("calibration early");
	cal_late_a: assert property (@(posedge clock) disable iff (!rst_n || userReset)
		calCnt_reg == 9'(CAL_CYCLES + 3) |-> calibrationDone) else $error("calibration late");
	cal_hold_a: assert property (@(posedge clock) disable iff (!rst_n || userReset)
		calibrationDone |=> calibrationDone) else $error("calibration dropped");
	beat_pair_a: assert property (@(posedge clock) disable iff (!rst_n || userReset)
		readReturnValid && !readLastBeat |=> readReturnValid && readLastBeat)
		else $error("read beat pair broken");
	last_in_pair_a: assert property (@(posedge clock) disable iff (!rst_n || userReset)
		readLastBeat |-> readReturnValid && $past(readReturnValid) && !$past(readLastBeat))
		else $error("read last misplaced");
	flags_idle_a: assert property (@(posedge clock) disable iff (!rst_n || userReset)
		!readReturnValid |-> uncorrectableErrorFlags == '0) else $error("flags without data");
	read_done_c: cover property (@(posedge clock) readLastBeat);
	write_taken_c: cover property (@(posedge clock)
		requestStrobe && requestAccept && requestCommand == CMD_WRITE);
	flag_seen_c: cover property (@(posedge clock) uncorrectableErrorFlags != '0);
endmodule // drup_user_port_sva

bind drup_user_port drup_user_port_sva sva (.clock, .rst_n, .userReset, .requestStrobe,
	.requestCommand, .requestAccept, .writeFifoReady, .readReturnValid, .readLastBeat,
	.uncorrectableErrorFlags, .calibrationDone);

/* test/drup_requester.sv */
// Requester model: issues commands and write words to the user port.
// Assumes the port clock; signals change just after rising edges.
`timescale 1ns/1ps
module drup_requester
	import drup_pkg::*;
(
	// Clock
	input wire logic clock,
	// Handshake
	input wire logic requestAccept,
	input wire logic writeFifoReady,
	// Request
	output logic requestStrobe,
	output logic [2:0] requestCommand,
	output logic [ADDR_W-1:0] requestAddress,
	output logic reservedSizeInput,
	output logic priorityBoost,
	// Write data
	output logic [DATA_W-1:0] writePayload,
	output logic [MASK_W-1:0] writeByteMask,
	output logic writePayloadValid,
	output logic writeLastBeat
);
	initial begin
		requestStrobe = 1'h0;
		requestCommand = 3'h7;
		requestAddress = '1;
		reservedSizeInput = 1'h0;
		priorityBoost = 1'h0;
		writePayload = '1;
		writeByteMask = '1;
		writePayloadValid = 1'h0;
		writeLastBeat = 1'h0;
	end
	task automatic issue(input logic [2:0] cmd, input logic [ADDR_W-1:0] addr, input logic hi);
		@(posedge clock);
		requestStrobe <= 1'h1;
		requestCommand <= cmd;
		requestAddress <= addr;
		priorityBoost <= hi;
		@(posedge clock);
		for (int i = 0; i < 4000 && requestAccept !== 1'h1; i++)
			@(posedge clock);
		requestStrobe <= 1'h0;
		requestCommand <= ~cmd;
		requestAddress <= ~addr;
		priorityBoost <= 1'h0;
	endtask
	task automatic word(input logic [DATA_W-1:0] d, input logic [MASK_W-1:0] m, input logic last);
		@(posedge clock);
		writePayloadValid <= 1'h1;
		writePayload <= d;
		writeByteMask <= m;
		writeLastBeat <= last;
		@(posedge clock);
		for (int i = 0; i < 4000 && writeFifoReady !== 1'h1; i++)
			@(posedge clock);
		writePayloadValid <= 1'h0;
		writePayload <= ~d;
		writeLastBeat <= ~last;
	endtask
endmodule // drup_requester

/* test/test_dram_user_request_port.sv */
// Testbench for the DRAM user request port with a requester model.
// Assumes the port's own store model answers reads.
`timescale 1ns/1ps
module test_dram_user_request_port;
	import drup_pkg::*;
	logic clock, clockMem, rst_n, userReset, requestStrobe, reservedSizeInput, priorityBoost;
	logic requestAccept, writePayloadValid, writeLastBeat, writeFifoReady;
	logic readReturnValid, readLastBeat, calibrationDone;
	logic [2:0] requestCommand;
	logic [ADDR_W-1:0] requestAddress;
	logic [DATA_W-1:0] writePayload, readReturnData;
	logic [MASK_W-1:0] writeByteMask;
	logic [ERR_W-1:0] uncorrectableErrorFlags, injectErr;
	int mismatches = 0;
	int n_compared = 0;
	localparam logic [DATA_W-1:0] DA = 128'h0123456789abcdeffedcba9876543210;
	localparam logic [DATA_W-1:0] DB = 128'h55aa55aa55aa55aa0f1e2d3c4b5a6978;
	drup_user_port dut (.clock, .clockMem, .rst_n, .userReset, .requestStrobe, .requestCommand,
		.requestAddress, .reservedSizeInput, .priorityBoost, .requestAccept, .writePayload,
		.writeByteMask, .writePayloadValid, .writeLastBeat, .writeFifoReady, .readReturnData,
		.readReturnValid, .readLastBeat, .uncorrectableErrorFlags, .injectErr, .calibrationDone);
	drup_requester req (.clock, .requestAccept, .writeFifoReady, .requestStrobe, .requestCommand,
		.requestAddress, .reservedSizeInput, .priorityBoost, .writePayload, .writeByteMask,
		.writePayloadValid, .writeLastBeat);
	initial begin
		clock = 1'h0;
		forever #5 clock = ~clock;
	end
	// Four memory edges per port edge
	initial begin
		clockMem = 1'h0;
		forever #1.25 clockMem = ~clockMem;
	end
	task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		if (mismatches == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic cal_check();
		int i;
		check(DATA_W'({requestAccept, writeFifoReady, readReturnValid, calibrationDone}), '0);
		for (i = 0; i < 400 && calibrationDone !== 1'h1; i++)
			@(posedge clock);
		check(DATA_W'(i >= CAL_CYCLES && i <= CAL_CYCLES + 3), 128'h1);
	endtask
	task automatic write_word(input logic [3:0] a, input logic [DATA_W-1:0] d,
		input logic [MASK_W-1:0] m);
		req.word(d, m, 1'h0);
		req.word(d, m, 1'h1);
		req.issue(CMD_WRITE, ADDR_W'(a), 1'h0);
		// Let the write commit before reading back
		repeat (30) @(posedge clock);
	endtask
	task automatic read_check(input logic [3:0] a, input logic [DATA_W-1:0] d,
		input logic [ERR_W-1:0] e);
		int i;
		req.issue(CMD_READ, ADDR_W'(a), 1'h0);
		for (i = 0; i < 100 && readReturnValid !== 1'h1; i++)
			@(posedge clock);
		check(readReturnData, d);
		check(DATA_W'(uncorrectableErrorFlags), DATA_W'(e));
		check(DATA_W'(readLastBeat), 128'h0);
		@(posedge clock);
		check(DATA_W'({readReturnValid, readLastBeat}), 128'h3);
	endtask
	// Boosted read offered straight after reset, long before calibration ends
	task automatic early_read(input logic [3:0] a, input logic [DATA_W-1:0] d);
		int i;
		userReset <= 1'h1;
		repeat (3) @(posedge clock);
		userReset <= 1'h0;
		req.issue(CMD_READ, ADDR_W'(a), 1'h1);
		check(DATA_W'(calibrationDone), 128'h1);
		for (i = 0; i < 100 && readReturnValid !== 1'h1; i++)
			@(posedge clock);
		check(readReturnData, d);
		check(DATA_W'(uncorrectableErrorFlags), 128'h0);
	endtask
	initial begin
		rst_n = 1'h0;
		userReset = 1'h0;
		injectErr = 8'h00;
		repeat (20) @(posedge clock);
		rst_n <= 1'h1;
		cal_check();
		write_word(4'h3, DA, 16'h0000);
		read_check(4'h3, DA, 8'h00);
		write_word(4'h3, DB, 16'hff00);
		read_check(4'h3, {DA[127:64], DB[63:0]}, 8'h00);
		@(posedge clock) injectErr <= 8'h05;
		read_check(4'h3, {DA[127:64], DB[63:0]}, 8'h05);
		@(posedge clock) injectErr <= 8'h00;
		userReset <= 1'h1;
		repeat (3) @(posedge clock);
		userReset <= 1'h0;
		cal_check();
		early_read(4'h3, {DA[127:64], DB[63:0]});
		print_verdict();
	end
	initial begin
		repeat (3000) @(posedge clock);
		mismatches++;
		print_verdict();
	end
endmodule // test_dram_user_request_port
